// File: twm_pkg.sv
/*
  Package for the 16-bit timer waveform-mode control block: register
  offsets, field positions, reset values, mode encodings and state types.
  Assumes a single 40 MHz core clock and an 8-bit AXI4-Lite byte address.
*/
`default_nettype none

package twm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL_A   = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h84;
  localparam logic [7:0] ADDR_CMP_A    = 8'h88;
  localparam logic [7:0] ADDR_CMP_B    = 8'h8C;
  localparam logic [7:0] ADDR_CAPT     = 8'h90;
  localparam logic [7:0] ADDR_COUNT    = 8'h94;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h98;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h9C;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'hA4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and write masks
  localparam int unsigned CHA_MODE_LSB = 6;
  localparam int unsigned CHB_MODE_LSB = 4;
  localparam int unsigned WGM_LOW_LSB  = 0;
  localparam int unsigned WGM_HIGH_LSB = 3;
  localparam logic [7:0]  CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0]  CTRL_B_WMASK = 8'h18;
  localparam int unsigned IRQ_OVF      = 0;
  localparam int unsigned IRQ_MATCH_A  = 1;
  localparam int unsigned IRQ_MATCH_B  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counter landmarks
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] BOTTOM     = 16'h0000;
  localparam logic [15:0] TOP_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform modes named in channel decoding
  localparam logic [3:0] WGM_PFC_CMPA  = 4'h9;
  localparam logic [3:0] WGM_PC_CMPA   = 4'hB;
  localparam logic [3:0] WGM_RESERVED  = 4'hD;
  localparam logic [3:0] WGM_FAST_CAPT = 4'hE;
  localparam logic [3:0] WGM_FAST_CMPA = 4'hF;

  typedef enum logic [2:0] {TWM_NORMAL, TWM_CTC, TWM_FAST, TWM_PC, TWM_PFC} twm_kind_e;
  typedef enum logic [1:0] {TWM_TOP_FIXED, TWM_TOP_CMPA, TWM_TOP_CAPT} twm_topsrc_e;
  typedef enum logic [1:0] {TWM_AT_NOW, TWM_AT_TOP, TWM_AT_BOTTOM, TWM_AT_MAX} twm_point_e;

  typedef struct packed {
    twm_kind_e   kind;
    twm_topsrc_e topSrc;
    logic [15:0] fixedTop;
    twm_point_e  update;
    twm_point_e  ovfAt;
  } twm_mode_s;

  typedef struct packed {
    logic [7:0]  ctrlA;
    logic [7:0]  ctrlB;
    logic [15:0] cmpBufA;
    logic [15:0] cmpBufB;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [15:0] capt;
    logic [15:0] count;
    logic        countUp;
    logic [1:0]  portDir;
    logic        waveA;
    logic        waveB;
    logic [2:0]  irqStat;
    logic [2:0]  irqEn;
    logic        irq;
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        pinOutA;
    logic        pinOutB;
    logic        pinOeA;
    logic        pinOeB;
  } twm_state_s;

  // One decode shared by counter, reload and flag logic
  function automatic twm_mode_s twm_decode(input logic [3:0] wgm);
    twm_mode_s m;
    begin
      m = '{TWM_NORMAL, TWM_TOP_FIXED, TOP_MAX, TWM_AT_NOW, TWM_AT_MAX};
      case (wgm)
        4'h1: m = '{TWM_PC, TWM_TOP_FIXED, TOP_8BIT, TWM_AT_TOP, TWM_AT_BOTTOM};
        4'h2: m = '{TWM_PC, TWM_TOP_FIXED, TOP_9BIT, TWM_AT_TOP, TWM_AT_BOTTOM};
        4'h3: m = '{TWM_PC, TWM_TOP_FIXED, TOP_10BIT, TWM_AT_TOP, TWM_AT_BOTTOM};
        4'h4: m = '{TWM_CTC, TWM_TOP_CMPA, TOP_MAX, TWM_AT_NOW, TWM_AT_MAX};
        4'h5: m = '{TWM_FAST, TWM_TOP_FIXED, TOP_8BIT, TWM_AT_BOTTOM, TWM_AT_TOP};
        4'h6: m = '{TWM_FAST, TWM_TOP_FIXED, TOP_9BIT, TWM_AT_BOTTOM, TWM_AT_TOP};
        4'h7: m = '{TWM_FAST, TWM_TOP_FIXED, TOP_10BIT, TWM_AT_BOTTOM, TWM_AT_TOP};
        4'h8: m = '{TWM_PFC, TWM_TOP_CAPT, TOP_MAX, TWM_AT_BOTTOM, TWM_AT_BOTTOM};
        4'h9: m = '{TWM_PFC, TWM_TOP_CMPA, TOP_MAX, TWM_AT_BOTTOM, TWM_AT_BOTTOM};
        4'hA: m = '{TWM_PC, TWM_TOP_CAPT, TOP_MAX, TWM_AT_TOP, TWM_AT_BOTTOM};
        4'hB: m = '{TWM_PC, TWM_TOP_CMPA, TOP_MAX, TWM_AT_TOP, TWM_AT_BOTTOM};
        4'hC: m = '{TWM_CTC, TWM_TOP_CAPT, TOP_MAX, TWM_AT_NOW, TWM_AT_MAX};
        4'hE: m = '{TWM_FAST, TWM_TOP_CAPT, TOP_MAX, TWM_AT_BOTTOM, TWM_AT_TOP};
        4'hF: m = '{TWM_FAST, TWM_TOP_CMPA, TOP_MAX, TWM_AT_BOTTOM, TWM_AT_TOP};
        default: m = '{TWM_NORMAL, TWM_TOP_FIXED, TOP_MAX, TWM_AT_NOW, TWM_AT_MAX};
      endcase
      return m;
    end
  endfunction : twm_decode

endpackage : twm_pkg

`default_nettype wire

// File: twm_timer_wave.sv
/*
  16-bit timer with waveform-mode selection and two compare output pins,
  registers behind an AXI4-Lite slave, one level interrupt.
  Assumes one 40 MHz clock, timer counting on every clock, and that the
  outside pad logic forms the wire from pin output and enable.
*/
// How it works
// - Channel A mode bits 7:6, B 5:4
// - Nonzero channel mode overrides the port pin; not in mode 13, nor mode 1 in PWM except A in 9/11/14/15
// - Pin driver follows the direction bit only
// - Non-PWM: off, toggle, clear, set on match
// - Fast mode 1: A toggles only in 14/15
// - Fast mode 2: clear at match, set BOTTOM
// - Fast mode 3: set at match, clear BOTTOM
// - Fast, compare equals TOP: act at TOP
// - Dual-slope mode 1: A toggles only 9/11
// - Dual mode 2: clear up, set down
// - Dual mode 3: set up, clear down
// - Mode joins low bits with second register
// - Modes 0,4,12: immediate reload, flag at MAX
// - Modes 1-3: fixed TOP, phase correct
// - Fast modes reload BOTTOM, flag at TOP
// - Modes 8,9: reload and flag at BOTTOM
// - Modes 10,11: reload TOP, flag BOTTOM
`timescale 1ns/1ps
`default_nettype none

module twm_timer_wave (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        portOutA,
  input  wire logic        portOutB,
  output var  logic        pinOutA,
  output var  logic        pinOeA,
  output var  logic        pinOutB,
  output var  logic        pinOeB,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_mapped(input logic [7:0] a);
    begin
      return (a == twm_pkg::ADDR_CTRL_A) || (a == twm_pkg::ADDR_CTRL_B) ||
             (a == twm_pkg::ADDR_CMP_A) || (a == twm_pkg::ADDR_CMP_B) ||
             (a == twm_pkg::ADDR_CAPT) || (a == twm_pkg::ADDR_COUNT) ||
             (a == twm_pkg::ADDR_PORT_DIR) || (a == twm_pkg::ADDR_IRQ_STAT) ||
             (a == twm_pkg::ADDR_IRQ_EN) || (a == twm_pkg::ADDR_IRQ_CLR);
    end
  endfunction : is_mapped

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    begin
      return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    end
  endfunction : merge16

  // Returns {connected, next level} for one channel
  function automatic logic [1:0] chan_step(input logic [1:0] com, input logic cur,
                                           input logic hit, input logic isA,
                                           input twm_pkg::twm_kind_e kind,
                                           input logic [3:0] wgm, input logic atTop,
                                           input logic atBot, input logic cmpIsTop,
                                           input logic up);
    logic conn;
    logic val;
    begin
      conn = (com != 2'h0);
      val  = cur;
      case (kind)
        twm_pkg::TWM_FAST: begin
          if (com == 2'h1) begin
            conn = isA && (wgm == twm_pkg::WGM_FAST_CAPT || wgm == twm_pkg::WGM_FAST_CMPA);
            if (conn && hit) begin
              val = ~cur;
            end
          end else if (com[1]) begin
            if (atBot) begin
              val = ~com[0];
            end
            // Compare at TOP: ignore the match, act at TOP
            if (cmpIsTop ? atTop : hit) begin
              val = com[0];
            end
          end
        end
        twm_pkg::TWM_PC, twm_pkg::TWM_PFC: begin
          if (com == 2'h1) begin
            conn = isA && (wgm == twm_pkg::WGM_PFC_CMPA || wgm == twm_pkg::WGM_PC_CMPA);
            if (conn && hit) begin
              val = ~cur;
            end
          end else if (com[1] && hit) begin
            val = up ? com[0] : ~com[0];
          end
        end
        default: begin
          if (hit) begin
            case (com)
              2'h1:    val = ~cur;
              2'h2:    val = 1'b0;
              2'h3:    val = 1'b1;
              default: val = cur;
            endcase
          end
        end
      endcase
      if (wgm == twm_pkg::WGM_RESERVED) begin
        conn = 1'b0;
      end
      return {conn, val};
    end
  endfunction : chan_step

  ////////////////////////////////////////////////////////////////////////////
  // State

  twm_pkg::twm_state_s s_q;
  twm_pkg::twm_state_s s_d;
  twm_pkg::twm_mode_s  mode;
  logic [3:0]          wgm;
  logic [15:0]         top;
  logic                atTop;
  logic                atBot;
  logic                atMax;
  logic                hitA;
  logic                hitB;
  logic                ovfEvt;
  logic                reload;
  logic [1:0]          stepA;
  logic [1:0]          stepB;
  logic                doWrite;
  logic [7:0]          wAddr;
  logic [31:0]         wData;
  logic [3:0]          wStrb;
  logic [2:0]          irqSet;
  logic [31:0]         rdWord;

  always_comb begin
    s_d = s_q;

    //////////////////////////////////////////////////////////////////////////
    // Timer core
    wgm  = {s_q.ctrlB[twm_pkg::WGM_HIGH_LSB +: 2], s_q.ctrlA[twm_pkg::WGM_LOW_LSB +: 2]};
    mode = twm_pkg::twm_decode(wgm);
    case (mode.topSrc)
      twm_pkg::TWM_TOP_CMPA: top = s_q.cmpA;
      twm_pkg::TWM_TOP_CAPT: top = s_q.capt;
      default:               top = mode.fixedTop;
    endcase
    atTop = (s_q.count == top);
    atBot = (s_q.count == twm_pkg::BOTTOM);
    atMax = (s_q.count == twm_pkg::TOP_MAX);
    hitA  = (s_q.count == s_q.cmpA);
    hitB  = (s_q.count == s_q.cmpB);

    if (mode.kind == twm_pkg::TWM_PC || mode.kind == twm_pkg::TWM_PFC) begin
      if (s_q.countUp) begin
        s_d.count   = atTop ? s_q.count - 16'h0001 : s_q.count + 16'h0001;
        s_d.countUp = ~atTop;
      end else begin
        s_d.count   = atBot ? s_q.count + 16'h0001 : s_q.count - 16'h0001;
        s_d.countUp = atBot;
      end
    end else begin
      // A TOP below the count runs on to MAX and wraps
      s_d.count   = atTop ? twm_pkg::BOTTOM : s_q.count + 16'h0001;
      s_d.countUp = 1'b1;
    end

    case (mode.update)
      twm_pkg::TWM_AT_TOP:    reload = atTop;
      twm_pkg::TWM_AT_BOTTOM: reload = atBot;
      default:                reload = 1'b1;
    endcase
    if (reload) begin
      s_d.cmpA = s_q.cmpBufA;
      s_d.cmpB = s_q.cmpBufB;
    end

    case (mode.ovfAt)
      twm_pkg::TWM_AT_TOP:    ovfEvt = atTop;
      twm_pkg::TWM_AT_BOTTOM: ovfEvt = atBot;
      twm_pkg::TWM_AT_MAX:    ovfEvt = atMax;
      default:                ovfEvt = 1'b0;
    endcase

    stepA = chan_step(s_q.ctrlA[twm_pkg::CHA_MODE_LSB +: 2], s_q.waveA, hitA, 1'b1,
                      mode.kind, wgm, atTop, atBot, s_q.cmpA == top, s_q.countUp);
    stepB = chan_step(s_q.ctrlA[twm_pkg::CHB_MODE_LSB +: 2], s_q.waveB, hitB, 1'b0,
                      mode.kind, wgm, atTop, atBot, s_q.cmpB == top, s_q.countUp);
    s_d.waveA = stepA[0];
    s_d.waveB = stepB[0];

    // Pins registered so every output comes from a flop
    s_d.pinOutA = stepA[1] ? stepA[0] : portOutA;
    s_d.pinOutB = stepB[1] ? stepB[0] : portOutB;
    s_d.pinOeA  = s_q.portDir[0];
    s_d.pinOeB  = s_q.portDir[1];

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    doWrite = s_d.awHave && s_d.wHave && !s_d.bvalid;
    wAddr   = s_d.awAddr;
    wData   = s_d.wData;
    wStrb   = s_d.wStrb;
    irqSet  = {hitB, hitA, ovfEvt};
    if (doWrite) begin
      s_d.awHave = 1'b0;
      s_d.wHave  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = is_mapped(wAddr) ? twm_pkg::RESP_OKAY : twm_pkg::RESP_SLVERR;
      if (wStrb[0]) begin
        case (wAddr)
          twm_pkg::ADDR_CTRL_A:   s_d.ctrlA = wData[7:0] & twm_pkg::CTRL_A_WMASK;
          twm_pkg::ADDR_CTRL_B:   s_d.ctrlB = wData[7:0] & twm_pkg::CTRL_B_WMASK;
          twm_pkg::ADDR_PORT_DIR: s_d.portDir = wData[1:0];
          twm_pkg::ADDR_IRQ_EN:   s_d.irqEn = wData[2:0];
          twm_pkg::ADDR_IRQ_CLR:  s_d.irqStat = s_q.irqStat & ~wData[2:0];
          default:                s_d.irqEn = s_d.irqEn;
        endcase
      end
      case (wAddr)
        twm_pkg::ADDR_CMP_A: s_d.cmpBufA = merge16(s_q.cmpBufA, wData, wStrb);
        twm_pkg::ADDR_CMP_B: s_d.cmpBufB = merge16(s_q.cmpBufB, wData, wStrb);
        twm_pkg::ADDR_CAPT:  s_d.capt = merge16(s_q.capt, wData, wStrb);
        twm_pkg::ADDR_COUNT: s_d.count = merge16(s_q.count, wData, wStrb);
        default:             s_d.capt = s_d.capt;
      endcase
    end
    // Set after clear so an event in the clearing cycle survives
    s_d.irqStat = s_d.irqStat | irqSet;
    s_d.irq     = |(s_d.irqStat & s_d.irqEn);
    s_d.awready = !s_d.awHave && !s_d.bvalid;
    s_d.wready  = !s_d.wHave && !s_d.bvalid;

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    case (s_axi_araddr)
      twm_pkg::ADDR_CTRL_A:   rdWord = {24'h00_0000, s_q.ctrlA};
      twm_pkg::ADDR_CTRL_B:   rdWord = {24'h00_0000, s_q.ctrlB};
      twm_pkg::ADDR_CMP_A:    rdWord = {16'h0000, s_q.cmpBufA};
      twm_pkg::ADDR_CMP_B:    rdWord = {16'h0000, s_q.cmpBufB};
      twm_pkg::ADDR_CAPT:     rdWord = {16'h0000, s_q.capt};
      twm_pkg::ADDR_COUNT:    rdWord = {16'h0000, s_q.count};
      twm_pkg::ADDR_PORT_DIR: rdWord = {30'h0000_0000, s_q.portDir};
      twm_pkg::ADDR_IRQ_STAT: rdWord = {29'h0000_0000, s_q.irqStat};
      twm_pkg::ADDR_IRQ_EN:   rdWord = {29'h0000_0000, s_q.irqEn};
      default:                rdWord = 32'h0000_0000;
    endcase
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rdWord;
      s_d.rresp  = is_mapped(s_axi_araddr) ? twm_pkg::RESP_OKAY : twm_pkg::RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.ctrlA   <= twm_pkg::CTRL_RESET;
      s_q.ctrlB   <= twm_pkg::CTRL_RESET;
      s_q.count   <= twm_pkg::WORD_RESET;
      s_q.countUp <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign pinOutA       = s_q.pinOutA;
  assign pinOeA        = s_q.pinOeA;
  assign pinOutB       = s_q.pinOutB;
  assign pinOeB        = s_q.pinOeB;
  assign irq           = s_q.irq;

endmodule : twm_timer_wave

`default_nettype wire

// File: twm_timer_wave_sva.sv
/*
  Checker for twm_timer_wave: bus handshakes, answers and pin enable.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module twm_timer_wave_sva (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pinOeA,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  AST_WR_ANSWER: assert property (wrTaken |=> s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  AST_READY_BACK: assert property ($fell(s_axi_bvalid) |-> ##[1:2]
    (s_axi_awready && s_axi_wready)) else $error("write path not reopened");
  AST_WR_UNMAPPED: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr > twm_pkg::ADDR_IRQ_CLR |=>
    s_axi_bresp == twm_pkg::RESP_SLVERR) else $error("unmapped write not refused");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > twm_pkg::ADDR_IRQ_CLR |=> s_axi_rresp == twm_pkg::RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_OE_CAUSE: assert property ($changed(pinOeA) |->
    $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2)) else $error("driver enable moved alone");

  COV_WRITE: cover property (wrTaken);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_IRQ: cover property ($rose(irq));
  COV_OE: cover property ($rose(pinOeA));
endmodule : twm_timer_wave_sva

bind twm_timer_wave twm_timer_wave_sva twm_timer_wave_sva_i (
  .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pinOeA, .irq
);

`default_nettype wire

// File: twm_testbench.sv
/*
  Self-checking bench for twm_timer_wave: registers, pins, interrupt, modes.
  Assumes the checker is bound separately; the timer counts every clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct {
    logic [3:0]  wgm;
    logic [1:0]  om;
    logic [15:0] cmp;
    int          win;
    int          high;
  } twm_case_s;

  logic        core_clk, rst_n, portOutA, portOutB;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pinOutA, pinOeA, pinOutB, pinOeB, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, wrsp;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          hi;
  int          lo;
  // Window spans whole periods, so phase at start does not matter
  twm_case_s tc [14] = '{ // Reserved mode 13 never chosen
    '{4'h4, 2'h1, 16'h001F, 64, 32},
    '{4'h4, 2'h3, 16'h001F, 64, 64},
    '{4'h4, 2'h2, 16'h001F, 64, 0},
    '{4'hC, 2'h1, 16'h003F, 128, 64},
    '{4'h5, 2'h2, 16'h0040, 256, 64},
    '{4'h5, 2'h3, 16'h0040, 256, 192},
    '{4'h5, 2'h1, 16'h0040, 256, 0},
    '{4'hF, 2'h1, 16'h003F, 128, 64},
    '{4'hE, 2'h2, 16'h003F, 64, 63},
    '{4'h1, 2'h2, 16'h0040, 510, 128},
    '{4'h1, 2'h3, 16'h0040, 510, 382},
    '{4'hB, 2'h1, 16'h003F, 252, 126},
    '{4'h9, 2'h1, 16'h003F, 252, 126},
    '{4'h8, 2'h1, 16'h003F, 252, 0}
  };

  twm_timer_wave twm_timer_wave_i (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portOutA, .portOutB, .pinOutA,
    .pinOeA, .pinOutB, .pinOeB, .irq
  );

  always #12.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Hold each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitc

  // Ceiling well above the roughly 12k cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {core_clk, rst_n, portOutA, portOutB, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    waitc(12);
    rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      if (k != 5) begin
        rd(twm_pkg::ADDR_CTRL_A + 8'(4 * k));
        check(rdv, 32'h0);
      end
    end
    wr(twm_pkg::ADDR_CTRL_A, 32'hFFFF_FFFF);
    rd(twm_pkg::ADDR_CTRL_A);
    check(rdv, 32'h0000_00F3);
    wr(twm_pkg::ADDR_CTRL_B, 32'hFFFF_FFFF);
    rd(twm_pkg::ADDR_CTRL_B);
    check(rdv, 32'h0000_0018);
    wr(twm_pkg::ADDR_CMP_A, 32'h1234_ABCD);
    rd(twm_pkg::ADDR_CMP_A);
    check(rdv, 32'h0000_ABCD);
    wr(8'hB0, 32'h1);
    check({30'h0, wrsp}, {30'h0, twm_pkg::RESP_SLVERR});
    rd(8'hB0);
    check({rsp, rdv[29:0]}, {twm_pkg::RESP_SLVERR, 30'h0});
    wr(twm_pkg::ADDR_CTRL_A, 32'h0);
    wr(twm_pkg::ADDR_CTRL_B, 32'h0);
    $display("Test registers done");
    // Both channels off: pins follow port data, enables follow direction
    for (int i = 0; i < 4; i++) begin
      portOutB <= i[0];
      portOutA <= i[1];
      wr(twm_pkg::ADDR_PORT_DIR, 32'(i));
      waitc(3);
      check({pinOeB, pinOeA, pinOutB, pinOutA}, {i[1], i[0], i[0], i[1]});
    end
    portOutA <= 1'b0;
    $display("Test pins done");
    // Free running mode: overflow only near the top of the count
    wr(twm_pkg::ADDR_IRQ_EN, 32'h1);
    wr(twm_pkg::ADDR_COUNT, 32'h0);
    wr(twm_pkg::ADDR_IRQ_CLR, 32'h7);
    waitc(3);
    check(irq, 1'b0);
    wr(twm_pkg::ADDR_COUNT, 32'h0000_FFF0);
    waitc(30);
    check(irq, 1'b1);
    wr(twm_pkg::ADDR_IRQ_STAT, 32'h0);
    rd(twm_pkg::ADDR_IRQ_STAT);
    check(rdv[0], 1'b1);
    wr(twm_pkg::ADDR_IRQ_EN, 32'h0);
    waitc(3);
    check(irq, 1'b0);
    wr(twm_pkg::ADDR_IRQ_EN, 32'h1);
    waitc(3);
    check(irq, 1'b1);
    wr(twm_pkg::ADDR_IRQ_CLR, 32'h1);
    waitc(3);
    check(irq, 1'b0);
    rd(twm_pkg::ADDR_IRQ_STAT);
    check(rdv[0], 1'b0);
    $display("Test interrupt done");
    wr(twm_pkg::ADDR_CAPT, 32'h0000_003F);
    foreach (tc[k]) begin
      wr(twm_pkg::ADDR_CTRL_A, {24'h0, tc[k].om, 4'h0, tc[k].wgm[1:0]});
      wr(twm_pkg::ADDR_CTRL_B, {27'h0, tc[k].wgm[3:2], 3'h0});
      wr(twm_pkg::ADDR_CMP_A, {16'h0, tc[k].cmp});
      wr(twm_pkg::ADDR_COUNT, 32'h0);
      waitc(600);
      hi = 0;
      lo = 0;
      repeat (tc[k].win) begin
        @(posedge core_clk);
        if (pinOutA === 1'b1) hi++;
        else if (pinOutA === 1'b0) lo++;
      end
      check(hi, tc[k].high);
      // Low count too, so an unknown pin cannot pass as low
      check(lo, tc[k].win - tc[k].high);
      $display("Test waveform %0d done", k);
    end
    // Channel B field alone in normal mode: clear, then set on match
    wr(twm_pkg::ADDR_CTRL_B, 32'h0);
    wr(twm_pkg::ADDR_CMP_B, 32'h0000_0010);
    for (int j = 2; j < 4; j++) begin
      wr(twm_pkg::ADDR_CTRL_A, 32'(j << twm_pkg::CHB_MODE_LSB));
      wr(twm_pkg::ADDR_COUNT, 32'h0);
      waitc(24);
      check(pinOutB, j[0]);
    end
    $display("Test channel B done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
